// *** common/dram_ctrl_pkg.sv ***
// shared constants and carrier types for the dram refresh controller
`default_nettype none
package dram_ctrl_pkg;
   localparam int CLK_PERIOD_NS = 40;
   localparam int ADDR_W        = 10;
   localparam int DATA_W        = 16;
   localparam int CNT_W         = 12;
   localparam int BURST_W       = 11;
   localparam int SYNC_STAGES   = 3;
   // times as printed, in their own units
   localparam int SELF_ENTRY_US           = 100;
   localparam int EXIT_PRE_FAST_NS        = 84;
   localparam int EXIT_PRE_SLOW_NS        = 104;
   localparam int COL_HOLD_NS             = 35;
   localparam int WRITE_DELAY_FAST_NS     = 63;
   localparam int WRITE_DELAY_SLOW_NS     = 70;
   localparam int COL_PULSE_FAST_NS       = 45;
   localparam int COL_PULSE_SLOW_NS       = 50;
   localparam int ACCESS_FAST_NS          = 45;
   localparam int ACCESS_SLOW_NS          = 50;
   localparam int REFRESH_ROW_LOW_NS      = 100;
   localparam int BURST_LEN               = 1024;
   // least times round up to whole cycles
   localparam int SELF_ENTRY_CYC     = (SELF_ENTRY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int EXIT_PRE_FAST_CYC  = (EXIT_PRE_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int EXIT_PRE_SLOW_CYC  = (EXIT_PRE_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int COL_HOLD_CYC       = (COL_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WR_DLY_FAST_CYC    = (WRITE_DELAY_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WR_DLY_SLOW_CYC    = (WRITE_DELAY_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int COL_PULSE_FAST_CYC = (COL_PULSE_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int COL_PULSE_SLOW_CYC = (COL_PULSE_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // data sampling waits for the access time, so it rounds up as well
   localparam int ACCESS_FAST_CYC    = (ACCESS_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACCESS_SLOW_CYC    = (ACCESS_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ROW_LOW_CYC        = (REFRESH_ROW_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // pin reset values: strobes idle high, bus released
   localparam logic STROBE_IDLE = 1'b1;

   typedef enum logic [1:0] {
      OP_REFRESH,
      OP_SELF_ENTER,
      OP_SELF_EXIT,
      OP_COUNTER_TEST
   } op_t;

   typedef struct packed {
      op_t               op;
      logic [ADDR_W-1:0] col;
      logic [DATA_W-1:0] wdata;
   } cmd_t;

   typedef struct packed {
      logic              ras_n;
      logic              cas_n;
      logic              we_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq;
      logic              dq_oe;
   } pins_t;
endpackage
`default_nettype wire

// *** logic/dram_refresh_host.sv ***
// host-side strobe sequencer: refresh, self refresh and counter test
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1: enter self refresh: CAS low before RAS, both low at least 100 us.
// R2: device refreshes by itself at fixed intervals from its own row counter.
// R3: device needs no clock or row address while in self refresh.
// R4: exit self refresh: raise RAS and CAS, keep RAS high the precharge time.
// R5: distributed refresh meeting the period limit needs no extra burst around self refresh.
// R6: burst or row-only refresh style needs 1024 refreshes before entry and after exit.
// R7: counter test: keep column address stable 35 ns after latching CAS fall.
// R8: counter test write strobe waits 63 or 70 ns after CAS falls.
// R9: counter test CAS width and RAS hold 45/50 ns; data valid by then.
// R10: each column-first refresh uses and then advances the device row counter.
// R11: counter test row comes from device counter, column from second CAS fall.
// R12: no accesses during self refresh until exit precharge has elapsed.
module dram_refresh_host
   import dram_ctrl_pkg::*;
#(
   parameter bit FAST_GRADE = 1'b1
) (
   input  wire  logic                       clk_in,
   input  wire  logic                       srst_in,
   input  wire  logic                       cmd_valid_in,
   input  wire  dram_ctrl_pkg::cmd_t        cmd_in,
   input  wire  logic                       burst_mode_in,
   input  wire  logic [dram_ctrl_pkg::DATA_W-1:0] dq_in,
   output var   logic                       cmd_ready_out,
   output var   logic                       done_out,
   output var   logic                       in_self_out,
   output var   logic [dram_ctrl_pkg::DATA_W-1:0] rdata_out,
   output var   dram_ctrl_pkg::pins_t       pins_out
);
   import dram_ctrl_pkg::*;
   localparam int EXIT_CYC  = FAST_GRADE ? EXIT_PRE_FAST_CYC : EXIT_PRE_SLOW_CYC;
   localparam int WD_CYC    = FAST_GRADE ? WR_DLY_FAST_CYC : WR_DLY_SLOW_CYC;
   localparam int PULSE_CYC = FAST_GRADE ? COL_PULSE_FAST_CYC : COL_PULSE_SLOW_CYC;
   localparam int ACC_CYC   = FAST_GRADE ? ACCESS_FAST_CYC : ACCESS_SLOW_CYC;
   // read sample covers the three stages plus the agreement register behind them
   localparam int RD_RAW    = ACC_CYC + SYNC_STAGES + 1;
   localparam int RD_CYC    = (RD_RAW > WD_CYC) ? RD_RAW : WD_CYC;
   typedef enum logic [3:0] {
      IDLE, REF_CAS, REF_RAS, REF_PRE, SELF_CAS, SELF_ENTRY, SELF_HOLD,
      SELF_EXIT_PRE, T_CAS1, T_RAS, T_CASHI, T_READ, T_WRITE, T_PRE
   } fsm_t;
   typedef struct packed {
      fsm_t               state;
      logic [CNT_W-1:0]   cnt;
      logic [BURST_W-1:0] burst_left;
      logic               goal_self;
      logic               burst_sel;
      logic [DATA_W-1:0]  wdata;
      logic [DATA_W-1:0]  rdata;
      logic               ready;
      logic               done;
      logic               in_self;
      pins_t              pins;
   } host_t;
   host_t             r_reg;
   host_t             r_next;
   logic [DATA_W-1:0] dq_sync;
   logic              accept;
   pin_sync #(
      .WIDTH (DATA_W)
   ) u_dq_sync (
      .clk_in    (clk_in),
      .srst_in   (srst_in),
      .pin_in    (dq_in),
      .value_out (dq_sync)
   );
   assign accept = cmd_valid_in && r_reg.ready;
   always_comb begin
      r_next      = r_reg;
      r_next.done = 1'b0;
      if (r_reg.cnt != '0) begin
         r_next.cnt = r_reg.cnt - 1'b1;
      end
      case (r_reg.state)
         IDLE: begin
            if (accept) begin
               case (cmd_in.op)
                  OP_REFRESH: begin
                     r_next.burst_left = BURST_W'(1);
                     r_next.goal_self  = 1'b0;
                     r_next.pins.cas_n = 1'b0;
                     r_next.state      = REF_CAS;
                  end
                  OP_SELF_ENTER: begin
                     r_next.burst_sel  = burst_mode_in;
                     r_next.goal_self  = 1'b1;
                     r_next.pins.cas_n = 1'b0;
                     if (burst_mode_in) begin
                        r_next.burst_left = BURST_W'(BURST_LEN); // [R6]
                        r_next.state      = REF_CAS;
                     end else begin
                        r_next.state = SELF_CAS; // [R5]
                     end
                  end
                  OP_COUNTER_TEST: begin
                     r_next.pins.addr  = cmd_in.col; // [R7]
                     r_next.wdata      = cmd_in.wdata;
                     r_next.pins.cas_n = 1'b0;
                     r_next.state      = T_CAS1;
                  end
                  default: r_next.state = IDLE;
               endcase
            end
         end
         REF_CAS: begin
            // row comes from the device counter, so address is left alone
            r_next.pins.ras_n = 1'b0; // [R10]
            r_next.cnt        = CNT_W'(ROW_LOW_CYC);
            r_next.state      = REF_RAS;
         end
         REF_RAS: begin
            if (r_reg.cnt <= CNT_W'(1)) begin
               r_next.pins.ras_n = 1'b1;
               r_next.pins.cas_n = 1'b1;
               r_next.burst_left = r_reg.burst_left - 1'b1;
               r_next.cnt        = CNT_W'(EXIT_CYC);
               r_next.state      = REF_PRE;
            end
         end
         REF_PRE: begin
            if (r_reg.cnt <= CNT_W'(1)) begin
               if (r_reg.burst_left != '0) begin
                  r_next.pins.cas_n = 1'b0;
                  r_next.state      = REF_CAS;
               end else if (r_reg.goal_self) begin
                  r_next.pins.cas_n = 1'b0;
                  r_next.state      = SELF_CAS;
               end else begin
                  r_next.done  = 1'b1;
                  r_next.state = IDLE;
               end
            end
         end
         SELF_CAS: begin
            r_next.pins.ras_n = 1'b0; // [R1]
            r_next.cnt        = CNT_W'(SELF_ENTRY_CYC);
            r_next.in_self    = 1'b1;
            r_next.state      = SELF_ENTRY;
         end
         SELF_ENTRY: begin
            // strobes held low; exit refused until the entry time has passed
            if (r_reg.cnt <= CNT_W'(1)) begin
               r_next.done  = 1'b1; // [R1]
               r_next.state = SELF_HOLD;
            end
         end
         SELF_HOLD: begin
            if (accept && cmd_in.op == OP_SELF_EXIT) begin
               r_next.pins.ras_n = 1'b1; // [R4]
               r_next.pins.cas_n = 1'b1;
               r_next.cnt        = CNT_W'(EXIT_CYC);
               r_next.state      = SELF_EXIT_PRE;
            end
         end
         SELF_EXIT_PRE: begin
            if (r_reg.cnt <= CNT_W'(1)) begin
               r_next.in_self   = 1'b0; // [R12]
               r_next.goal_self = 1'b0;
               if (r_reg.burst_sel) begin
                  r_next.burst_left = BURST_W'(BURST_LEN); // [R6]
                  r_next.pins.cas_n = 1'b0;
                  r_next.state      = REF_CAS;
               end else begin
                  r_next.done  = 1'b1; // [R5]
                  r_next.state = IDLE;
               end
            end
         end
         T_CAS1: begin
            r_next.pins.ras_n = 1'b0; // [R11]
            r_next.cnt        = CNT_W'(PULSE_CYC);
            r_next.state      = T_RAS;
         end
         T_RAS: begin
            if (r_reg.cnt <= CNT_W'(1)) begin
               r_next.pins.cas_n = 1'b1;
               r_next.cnt        = CNT_W'(1);
               r_next.state      = T_CASHI;
            end
         end
         T_CASHI: begin
            // second fall latches the column; address held to the end
            r_next.pins.cas_n = 1'b0; // [R11]
            r_next.cnt        = CNT_W'(RD_CYC);
            r_next.state      = T_READ;
         end
         T_READ: begin
            if (r_reg.cnt <= CNT_W'(1)) begin
               r_next.rdata      = dq_sync; // [R9]
               r_next.pins.we_n  = 1'b0; // [R8]
               r_next.pins.dq    = r_reg.wdata;
               r_next.pins.dq_oe = 1'b1;
               r_next.cnt        = CNT_W'(PULSE_CYC);
               r_next.state      = T_WRITE;
            end
         end
         T_WRITE: begin
            if (r_reg.cnt <= CNT_W'(1)) begin
               r_next.pins.cas_n = 1'b1; // [R9]
               r_next.pins.ras_n = 1'b1;
               r_next.pins.we_n  = 1'b1;
               r_next.pins.dq_oe = 1'b0;
               r_next.cnt        = CNT_W'(EXIT_CYC);
               r_next.state      = T_PRE;
            end
         end
         T_PRE: begin
            if (r_reg.cnt <= CNT_W'(1)) begin
               r_next.done  = 1'b1;
               r_next.state = IDLE;
            end
         end
         default: r_next.state = IDLE;
      endcase
      // any command is invited whenever the next state is IDLE or SELF_HOLD
      r_next.ready = (r_next.state == IDLE) || (r_next.state == SELF_HOLD); // [R12]
   end
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         r_reg            <= '0;
         r_reg.state      <= IDLE;
         r_reg.pins.ras_n <= STROBE_IDLE;
         r_reg.pins.cas_n <= STROBE_IDLE;
         r_reg.pins.we_n  <= STROBE_IDLE;
      end else begin
         r_reg <= r_next;
      end
   end

   assign cmd_ready_out = r_reg.ready;
   assign done_out      = r_reg.done;
   assign in_self_out   = r_reg.in_self;
   assign rdata_out     = r_reg.rdata;
   assign pins_out      = r_reg.pins;
   // helper counters watched by the checks below
   logic [CNT_W-1:0]   cas_low_cnt;
   logic [CNT_W-1:0]   both_low_cnt;
   logic [BURST_W:0]   cbr_cnt;
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         cas_low_cnt  <= '0;
         both_low_cnt <= '0;
         cbr_cnt      <= '0;
      end else begin
         cas_low_cnt  <= r_reg.pins.cas_n ? '0 :
                         (&cas_low_cnt ? cas_low_cnt : cas_low_cnt + 1'b1);
         both_low_cnt <= (r_reg.pins.cas_n || r_reg.pins.ras_n) ? '0 :
                         (&both_low_cnt ? both_low_cnt : both_low_cnt + 1'b1);
         if (accept) begin
            cbr_cnt <= '0;
         end else if (r_reg.state == REF_CAS) begin
            cbr_cnt <= cbr_cnt + 1'b1;
         end
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);
   sequence seq_ras_precharge;
      r_reg.pins.ras_n [*3];
   endsequence
   sequence seq_write_phase;
      !r_reg.pins.we_n && !r_reg.pins.cas_n && r_reg.pins.dq_oe;
   endsequence
   a_self_entry_time: assert property ( // [R1]
      $rose(r_reg.state == SELF_HOLD) |-> both_low_cnt >= CNT_W'(SELF_ENTRY_CYC - 1))
      else $error("self refresh held for too short an entry time");
   a_exit_precharge: assert property ( // [R4]
      $rose(r_reg.pins.ras_n) |-> seq_ras_precharge)
      else $error("ras high shorter than exit precharge");
   a_distrib_no_burst: assert property ( // [R5]
      accept && cmd_in.op == OP_SELF_ENTER && !burst_mode_in && r_reg.state == IDLE
      |-> ##1 r_reg.state == SELF_CAS ##1 !r_reg.pins.ras_n)
      else $error("distributed mode inserted extra refresh");
   a_burst_before: assert property ( // [R6]
      $rose(r_reg.state == SELF_ENTRY) && r_reg.burst_sel |-> cbr_cnt == (BURST_W+1)'(BURST_LEN))
      else $error("refresh burst before self refresh is not full length");
   a_col_hold: assert property ( // [R7]
      $fell(r_reg.pins.cas_n) && r_reg.state == T_READ |-> $stable(r_reg.pins.addr) [*2])
      else $error("column address changed during hold");
   a_write_delay: assert property ( // [R8]
      $fell(r_reg.pins.we_n) |-> cas_low_cnt >= CNT_W'(WD_CYC))
      else $error("write strobe too soon after cas fall");
   a_cas_width: assert property ( // [R9]
      $rose(r_reg.pins.cas_n) && $past(r_reg.state == T_WRITE)
      |-> $past(cas_low_cnt) >= CNT_W'(PULSE_CYC + RD_CYC - 1))
      else $error("counter test cas pulse too short");
   a_write_window: assert property ( // [R9]
      $fell(r_reg.pins.we_n) |-> seq_write_phase ##1 !r_reg.pins.ras_n)
      else $error("ras released before write completes");
   a_self_no_access: assert property ( // [R12]
      r_reg.in_self |-> r_reg.pins.we_n && !r_reg.pins.dq_oe)
      else $error("access issued during self refresh");
endmodule // dram_refresh_host
`default_nettype wire

// *** logic/pin_sync.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 16
) (
   input  wire  logic             clk_in,
   input  wire  logic             srst_in,
   input  wire  logic [WIDTH-1:0] pin_in,
   output var   logic [WIDTH-1:0] value_out
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] value;
   } sync_t;

   sync_t r_reg;
   sync_t r_next;

   always_comb begin
      r_next    = r_reg;
      r_next.s1 = pin_in;
      r_next.s2 = r_reg.s1;
      r_next.s3 = r_reg.s2;
      // only stages two and three are compared; stage one may be metastable
      if (r_reg.s2 == r_reg.s3) begin
         r_next.value = r_reg.s3;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign value_out = r_reg.value;
endmodule // pin_sync
`default_nettype wire

// *** sim/dram_device_model.sv ***
// behavioural model of the refreshed dram as seen from its pins
`timescale 1ns/1ps
`default_nettype none
module dram_device_model
   import dram_ctrl_pkg::*;
#(
   parameter bit FAST_GRADE   = 1'b1,
   parameter int SELF_TICK_NS = 15000
) (
   input  wire dram_ctrl_pkg::pins_t             pins_in,
   input  wire logic [dram_ctrl_pkg::DATA_W-1:0] dq_bus_in,
   output var  logic [dram_ctrl_pkg::DATA_W-1:0] dq_out
);
   localparam real PRE = FAST_GRADE ? EXIT_PRE_FAST_NS : EXIT_PRE_SLOW_NS;
   localparam real WD  = FAST_GRADE ? WRITE_DELAY_FAST_NS : WRITE_DELAY_SLOW_NS;
   localparam real PW  = FAST_GRADE ? COL_PULSE_FAST_NS : COL_PULSE_SLOW_NS;
   localparam real ACC = FAST_GRADE ? ACCESS_FAST_NS : ACCESS_SLOW_NS;
   localparam real HLD = SELF_ENTRY_US * 1000.0;
   int unsigned       faults     = 0;
   int unsigned       refreshes  = 0;
   int unsigned       selfs      = 0;
   logic [ADDR_W-1:0] row_cnt    = '0;
   logic [ADDR_W-1:0] row        = '0;
   logic [ADDR_W-1:0] col        = '0;
   logic [DATA_W-1:0] last_write = '0;
   logic [DATA_W-1:0] mem [int];
   bit                in_test    = 1'b0;
   bit                column_strobe_first_refresh        = 1'b0;
   realtime           t_rf       = 0;
   realtime           t_rr       = -1000;
   realtime           t_c2       = 0;

   initial dq_out = 16'h5A5A;

   task automatic fault(input string msg);
      $display("ERROR %0t model: %s", $realtime, msg);
      faults++;
   endtask

   function automatic logic [DATA_W-1:0] word_at();
      int k;
      k = int'({row, col});
      return mem.exists(k) ? mem[k] : {row[5:0], col};
   endfunction

   always @(negedge pins_in.ras_n) begin
      if ($realtime - t_rr < PRE) fault("precharge short");
      t_rf = $realtime;
      column_strobe_first_refresh = !pins_in.cas_n;
      if (column_strobe_first_refresh) begin
         row = row_cnt;
         row_cnt = row_cnt + 1'b1;
      end
   end

   always @(posedge pins_in.ras_n) begin
      if ($realtime - t_rf >= HLD) selfs++;
      else if (column_strobe_first_refresh) refreshes++;
      if (in_test && $realtime - t_c2 < PW) fault("row hold short");
      in_test = 1'b0;
      t_rr = $realtime;
   end

   always @(negedge pins_in.cas_n) begin
      if (!pins_in.ras_n) begin
         in_test = 1'b1;
         col = pins_in.addr;
         t_c2 = $realtime;
         // worst case: garbage until the access time runs out
         #(ACC);
         if (!pins_in.cas_n && pins_in.we_n) dq_out = word_at();
      end
   end

   always @(negedge pins_in.we_n) begin
      if (in_test) begin
         if ($realtime - t_c2 < WD) fault("write strobe early");
         #1;
         last_write = dq_bus_in;
         mem[int'({row, col})] = dq_bus_in;
      end
   end

   always @(posedge pins_in.cas_n) begin
      if (in_test && $realtime - t_c2 < PW) fault("column pulse short");
      // released bus flips to the inverse of whatever it last showed
      dq_out = ~dq_out;
   end

   always @(pins_in.addr) begin
      if (in_test && !pins_in.cas_n && $realtime - t_c2 < COL_HOLD_NS) begin
         fault("column moved");
      end
   end

   // own timer: no clock or row address needed while held
   always begin
      #(SELF_TICK_NS);
      if (!pins_in.ras_n && !pins_in.cas_n && $realtime - t_rf >= HLD) begin
         row_cnt = row_cnt + 1'b1;
      end
   end
endmodule // dram_device_model
`default_nettype wire

// *** sim/dram_refresh_host_test.sv ***
// self-checking bench for the dram refresh host
`timescale 1ns/1ps
`default_nettype none
module dram_refresh_host_test;
   import dram_ctrl_pkg::*;
   logic              clk_in        = 1'b0;
   logic              srst_in       = 1'b1;
   logic              cmd_valid_in  = 1'b0;
   cmd_t              cmd_in        = '0;
   logic              burst_mode_in = 1'b0;
   logic [DATA_W-1:0] dq_in;
   logic [DATA_W-1:0] dq_dev;
   logic              cmd_ready_out;
   logic              done_out;
   logic              in_self_out;
   logic [DATA_W-1:0] rdata_out;
   pins_t             pins_out;
   int                fails         = 0;
   int                compares      = 0;
   logic [ADDR_W-1:0] row_exp       = '0;

   always #20 clk_in = ~clk_in;
   assign dq_in = pins_out.dq_oe ? pins_out.dq : dq_dev;

   dram_refresh_host #(.FAST_GRADE(1'b1)) uut (
      .clk_in(clk_in), .srst_in(srst_in), .cmd_valid_in(cmd_valid_in),
      .cmd_in(cmd_in), .burst_mode_in(burst_mode_in), .dq_in(dq_in),
      .cmd_ready_out(cmd_ready_out), .done_out(done_out),
      .in_self_out(in_self_out), .rdata_out(rdata_out), .pins_out(pins_out));

   dram_device_model #(.FAST_GRADE(1'b1)) model (
      .pins_in(pins_out), .dq_bus_in(dq_in), .dq_out(dq_dev));

   task automatic wrap_up();
      compares++;
      if (model.faults != 0) fails++;
      $display("checks %0d errors %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input bit ok, input string msg);
      compares++;
      if (!ok) begin
         $display("ERROR %0t %s", $realtime, msg);
         fails++;
      end
   endtask

   task automatic send(input op_t op, input logic [ADDR_W-1:0] col, input logic [DATA_W-1:0] wd);
      int n;
      n = 0;
      while (cmd_ready_out !== 1'b1) begin
         @(posedge clk_in);
         n++;
         if (n > 50) begin
            check(1'b0, "ready never rose");
            wrap_up();
         end
      end
      cmd_valid_in <= 1'b1;
      cmd_in <= '{op: op, col: col, wdata: wd};
      @(posedge clk_in);
      cmd_valid_in <= 1'b0;
   endtask

   task automatic do_cmd(input op_t op, input logic [ADDR_W-1:0] col,
                         input logic [DATA_W-1:0] wd, input int bound, output int cyc);
      send(op, col, wd);
      cyc = 0;
      do begin
         @(posedge clk_in);
         cyc++;
         if (cyc > bound) begin
            check(1'b0, "done never came");
            wrap_up();
         end
      end while (done_out !== 1'b1);
   endtask

   task automatic t_refresh();
      int c;
      int r0;
      r0 = model.refreshes;
      do_cmd(OP_REFRESH, '0, '0, 40, c);
      row_exp++;
      check(model.refreshes == r0 + 1, "refresh not seen");
      check(model.row_cnt === row_exp, "row counter not advanced");
   endtask

   task automatic t_counter(input logic [ADDR_W-1:0] col, input logic [DATA_W-1:0] wd);
      int c;
      do_cmd(OP_COUNTER_TEST, col, wd, 60, c);
      check(rdata_out === {row_exp[5:0], col}, "counter test read");
      check(model.last_write === wd, "counter test write");
      check(model.faults == 0, "counter test strobe timing");
      row_exp++;
   endtask

   task automatic t_exit_in_idle();
      int r0;
      r0 = model.refreshes;
      send(OP_SELF_EXIT, '0, '0);
      repeat (10) begin
         @(posedge clk_in);
         if (done_out === 1'b1) check(1'b0, "idle exit acted");
      end
      check(pins_out.ras_n === 1'b1 && model.refreshes == r0, "idle exit moved pins");
   endtask

   task automatic t_self(input logic burst);
      int c;
      int r0;
      int s0;
      int b;
      logic [ADDR_W-1:0] row0;
      r0 = model.refreshes;
      s0 = model.selfs;
      b = burst ? BURST_LEN : 0;
      burst_mode_in <= burst;
      do_cmd(OP_SELF_ENTER, '0, '0, 12000, c);
      check(c >= SELF_ENTRY_CYC, "self entry too short");
      check(in_self_out === 1'b1, "not held in self refresh");
      check(model.refreshes == r0 + b, "entry burst count");
      row0 = model.row_cnt;
      send(OP_REFRESH, '0, '0);
      // hold past one device tick so its own refresh must show
      repeat (400) @(posedge clk_in);
      check(pins_out.ras_n === 1'b0 && model.refreshes == r0 + b, "access in self");
      check(model.row_cnt !== row0, "no refresh while held");
      do_cmd(OP_SELF_EXIT, '0, '0, 9000, c);
      check(in_self_out === 1'b0, "still flagged in self");
      check(model.selfs == s0 + 1, "self refresh not held");
      check(model.refreshes == r0 + 2 * b, "exit burst count");
      // row moved on its own timer while held, so resync
      row_exp = model.row_cnt;
      t_refresh();
   endtask

   initial begin
      repeat (20) @(posedge clk_in);
      check(pins_out.ras_n === 1'b1 && pins_out.cas_n === 1'b1 && pins_out.dq_oe === 1'b0
            && cmd_ready_out === 1'b0 && in_self_out === 1'b0, "reset state");
      srst_in <= 1'b0;
      @(posedge clk_in);
      t_refresh();
      t_counter(10'h3FF, 16'hA5C3);
      t_counter(10'h000, 16'h0001);
      t_exit_in_idle();
      t_self(1'b0);
      t_self(1'b1);
      wrap_up();
   end
endmodule // dram_refresh_host_test
`default_nettype wire
